/* File: core/crcs_core.sv */
// 16-bit ccitt signature generator with its four bus registers
// assumes a single-request peripheral bus held until busReady is high
//
// Overview of operation
// - signature uses the ccitt polynomial, feedback from msb-numbered bits 0,4,11,15.
// - writing the seed register loads the signature; reading back returns it.
// - every data write is folded in; both results current by next read.
// - word data: low byte first cycle, high byte second; byte data one cycle.
// - parallel update equals serial lfsr fed eight bits, lsb first.
// - bytes written to the reversing data register are bit-reversed per byte.
// - bytes written to the normal data register enter unchanged.
// - appending the reversed checksum to the normal data register makes both result registers read zero.
// - software or a transfer master may write data; sources are not told apart.
// - all registers take word and byte access; low and high byte aliases.
// - mirrored result shows the signature bit-reversed and is read-only.
// - reading the reversing data register returns the normal data register.
module crcs_core #(
    parameter int DEPTH = crcs_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic busSel,
    input wire logic busWrite,
    input wire logic busByte,
    input wire logic [crcs_pkg::ADDR_W-1:0] busAddr,
    input wire logic [crcs_pkg::DATA_W-1:0] busWdata,
    output logic busReady,
    output logic [crcs_pkg::DATA_W-1:0] busRdata,
    output logic busRvalid
);
    import crcs_pkg::*;

    logic [DATA_W-1:0] dataIn_reg;
    logic [DATA_W-1:0] crc_reg;
    logic [DATA_W-1:0] crc_next;
    logic [BYTE_W-1:0] high_reg;
    logic highRev_reg;
    crcs_state_t state_reg;
    crcs_state_t state_next;

    logic [1:0] regIdx;
    logic hiByte;
    logic accept;
    logic isDataWrite;
    logic engineIdle;

    logic fifoInValid;
    logic fifoInReady;
    logic [ENTRY_W-1:0] fifoInData;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [ENTRY_W-1:0] fifoOutData;
    logic pop;

    // one serial lfsr step per data bit, lsb of the byte first
    function automatic logic [DATA_W-1:0] crcStep(
        input logic [DATA_W-1:0] crc,
        input logic [BYTE_W-1:0] b
    );
        logic [DATA_W-1:0] c;
        logic fb;
        c = crc;
        fb = 1'b0;
        for (int i = 0; i < BYTE_W; i++)
        begin
            fb = c[DATA_W-1] ^ b[i];
            c = {c[DATA_W-2:0], 1'b0} ^ (fb ? CCITT_POLY : '0);
        end
        crcStep = c;
    endfunction : crcStep

    function automatic logic [BYTE_W-1:0] revByte(
        input logic [BYTE_W-1:0] b
    );
        logic [BYTE_W-1:0] r;
        r = '0;
        for (int i = 0; i < BYTE_W; i++)
        begin
            r[i] = b[BYTE_W-1-i];
        end
        revByte = r;
    endfunction : revByte

    function automatic logic [DATA_W-1:0] mirror16(
        input logic [DATA_W-1:0] v
    );
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W; i++)
        begin
            r[i] = v[DATA_W-1-i];
        end
        mirror16 = r;
    endfunction : mirror16

    // byte writes carry their byte in wdata[7:0] for either alias
    function automatic logic [DATA_W-1:0] laneWrite(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wd,
        input logic isByte,
        input logic hi
    );
        logic [DATA_W-1:0] r;
        r = old;
        if (!isByte)
        begin
            r = wd;
        end
        else if (hi)
        begin
            r[DATA_W-1:BYTE_W] = wd[BYTE_W-1:0];
        end
        else
        begin
            r[BYTE_W-1:0] = wd[BYTE_W-1:0];
        end
        laneWrite = r;
    endfunction : laneWrite

    // byte reads of the high alias come back in the low lane
    function automatic logic [DATA_W-1:0] laneRead(
        input logic [DATA_W-1:0] v,
        input logic isByte,
        input logic hi
    );
        logic [DATA_W-1:0] r;
        r = v;
        if (isByte)
        begin
            r = hi ? {BYTE_ZERO, v[DATA_W-1:BYTE_W]}
                   : {BYTE_ZERO, v[BYTE_W-1:0]};
        end
        laneRead = r;
    endfunction : laneRead

    // the engine itself never learns which master wrote a byte
    function automatic logic [BYTE_W-1:0] prepByte(
        input logic [BYTE_W-1:0] b,
        input logic rev
    );
        prepByte = rev ? revByte(b) : b;
    endfunction : prepByte

    assign regIdx = busAddr[2:1];
    assign hiByte = busAddr[ADDR_HI_BYTE];
    assign isDataWrite = busWrite
        && (regIdx == IDX_DATA_IN || regIdx == IDX_DATA_IN_REVERSED);
    // nothing queued and no high byte left over
    assign engineIdle = !fifoOutValid && (state_reg == CRCS_ST_IDLE);

    // reads and seed writes wait for the queue to drain, so results
    // are always current; data writes wait only for a free slot
    always_comb
    begin
        busReady = 1'b1;
        if (isDataWrite)
        begin
            busReady = fifoInReady;
        end
        else if (busWrite && regIdx == IDX_SEED_AND_RESULT)
        begin
            busReady = engineIdle;
        end
        else if (!busWrite)
        begin
            busReady = engineIdle;
        end
    end

    assign accept = busSel && busReady;

    // queue entry holds the byte to use in the low lane
    always_comb
    begin
        fifoInValid = busSel && isDataWrite;
        fifoInData = '0;
        fifoInData[ENTRY_REV] = (regIdx == IDX_DATA_IN_REVERSED);
        fifoInData[ENTRY_WORD] = !busByte;
        if (busByte)
        begin
            fifoInData[BYTE_W-1:0] = busWdata[BYTE_W-1:0];
        end
        else
        begin
            fifoInData[DATA_W-1:0] = busWdata;
        end
    end

    // the queue keeps arrival order, so bytes keep the master's order
    crcs_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(DEPTH)
    ) dataQueue (
        .mclk(mclk),
        .rst(rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // a new entry is taken only once the previous word is finished
    assign fifoOutReady = (state_reg == CRCS_ST_IDLE);
    assign pop = fifoOutValid && fifoOutReady;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CRCS_ST_IDLE:
            begin
                if (pop && fifoOutData[ENTRY_WORD])
                begin
                    state_next = CRCS_ST_HIGH;
                end
            end
            CRCS_ST_HIGH:
            begin
                state_next = CRCS_ST_IDLE;
            end
            default:
            begin
                state_next = CRCS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg <= CRCS_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // high byte parked for the second cycle of a word
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            high_reg <= BYTE_ZERO;
            highRev_reg <= 1'b0;
        end
        else if (pop)
        begin
            high_reg <= fifoOutData[DATA_W-1:BYTE_W];
            highRev_reg <= fifoOutData[ENTRY_REV];
        end
    end

    always_comb
    begin
        crc_next = crc_reg;
        if (accept && busWrite && regIdx == IDX_SEED_AND_RESULT)
        begin
            crc_next = laneWrite(crc_reg, busWdata, busByte, hiByte);
        end
        else if (pop)
        begin
            // low byte at the even address goes first
            crc_next = crcStep(crc_reg,
                prepByte(fifoOutData[BYTE_W-1:0],
                    fifoOutData[ENTRY_REV]));
        end
        else if (state_reg == CRCS_ST_HIGH)
        begin
            crc_next = crcStep(crc_reg,
                prepByte(high_reg, highRev_reg));
        end
    end

    // appending the reversed checksum to the normal data register drives this to zero by itself
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            crc_reg <= RST_SEED_AND_RESULT;
        end
        else
        begin
            crc_reg <= crc_next;
        end
    end

    // both data registers share one store
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dataIn_reg <= RST_DATA_IN;
        end
        else if (accept && isDataWrite)
        begin
            dataIn_reg <= laneWrite(dataIn_reg, busWdata, busByte,
                hiByte);
        end
    end

    // read answer one cycle after the request is taken
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busRdata <= '0;
            busRvalid <= 1'b0;
        end
        else
        begin
            busRvalid <= accept && !busWrite;
            if (accept && !busWrite)
            begin
                case (regIdx)
                    IDX_DATA_IN:
                    begin
                        busRdata <= laneRead(dataIn_reg, busByte,
                            hiByte);
                    end
                    IDX_DATA_IN_REVERSED:
                    begin
                        busRdata <= laneRead(dataIn_reg, busByte,
                            hiByte);
                    end
                    IDX_SEED_AND_RESULT:
                    begin
                        busRdata <= laneRead(crc_reg, busByte,
                            hiByte);
                    end
                    IDX_RESULT_MIRRORED:
                    begin
                        busRdata <= laneRead(mirror16(crc_reg), busByte,
                            hiByte);
                    end
                    default:
                    begin
                        busRdata <= '0;
                    end
                endcase
            end
        end
    end

    // writes to the mirrored result are taken and dropped: it is
    // read-only and holds no storage of its own
endmodule : crcs_core

/* File: core/crcs_pkg.sv */
// constants shared by the signature generator and its data buffer
// assumes a 16-bit peripheral bus with byte addresses and a byte-access flag
package crcs_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 3;
    localparam int FIFO_DEPTH = 16;
    // entry layout: reverse flag, word flag, data
    localparam int ENTRY_W = DATA_W + 2;
    localparam int ENTRY_REV = DATA_W + 1;
    localparam int ENTRY_WORD = DATA_W;

    // register index, taken from address bits 2:1
    localparam logic [1:0] IDX_DATA_IN = 2'h0;
    localparam logic [1:0] IDX_DATA_IN_REVERSED = 2'h1;
    localparam logic [1:0] IDX_SEED_AND_RESULT = 2'h2;
    localparam logic [1:0] IDX_RESULT_MIRRORED = 2'h3;
    // printed byte offsets
    localparam logic [ADDR_W-1:0] OFS_DATA_IN = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_DATA_IN_REVERSED = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_SEED_AND_RESULT = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_RESULT_MIRRORED = 3'h6;
    localparam int ADDR_HI_BYTE = 0;

    localparam logic [DATA_W-1:0] RST_DATA_IN = 16'h0000;
    localparam logic [DATA_W-1:0] RST_SEED_AND_RESULT = 16'hFFFF;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    // x^16 + x^12 + x^5 + 1, shift-left form
    localparam logic [DATA_W-1:0] CCITT_POLY = 16'h1021;

    typedef enum logic [0:0] {
        CRCS_ST_IDLE = 1'b0,
        CRCS_ST_HIGH = 1'b1
    } crcs_state_t;
endpackage : crcs_pkg

/* File: core/crcs_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
module crcs_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST) ? '0 : p + AW'(1);
    endfunction : bump

    assign inReady = (count_reg != FULL);
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_reg <= bump(wrPtr_reg);
            end
            if (pop)
            begin
                rdPtr_reg <= bump(rdPtr_reg);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            count_reg <= '0;
        end
        else if (push && !pop)
        begin
            count_reg <= count_reg + ONE;
        end
        else if (pop && !push)
        begin
            count_reg <= count_reg - ONE;
        end
    end
endmodule : crcs_fifo

/* File: test/crcs_core_asserts.sv */
// bus-level assertions for the signature generator
// assumes binding to crcs_core, one clock, synchronous reset
module crcs_core_asserts #(
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic busSel,
    input wire logic busWrite,
    input wire logic busByte,
    input wire logic [crcs_pkg::ADDR_W-1:0] busAddr,
    input wire logic [crcs_pkg::DATA_W-1:0] busWdata,
    input wire logic busReady,
    input wire logic [crcs_pkg::DATA_W-1:0] busRdata,
    input wire logic busRvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    import crcs_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic rdTaken;
    logic dataWr;
    logic seedWr;
    assign rdTaken = busSel && !busWrite && busReady;
    assign dataWr = busSel && busWrite && busReady && !busAddr[2];
    assign seedWr = busSel && busWrite && busReady && busAddr[2:1] == 2'h2;
    function automatic logic [15:0] mir(logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
            r[i] = v[15-i];
        return r;
    endfunction : mir
    sequence rdOf(logic [2:0] a);
        rdTaken && !busByte && busAddr == a;
    endsequence
    sequence seedWord;
        seedWr && !busByte;
    endsequence
    a_read_answer: assert property (rdTaken |=> busRvalid)
        else $error("read not answered next cycle");
    a_answer_cause: assert property (busRvalid |-> $past(rdTaken))
        else $error("read answer without a request");
    a_rdata_holds: assert property
        (!busRvalid && !$past(rst) |-> $stable(busRdata))
        else $error("read data moved without an answer");
    a_byte_narrow: assert property
        (busRvalid && $past(busByte) |-> busRdata[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    a_seed_readback: assert property
        (seedWord ##1 rdOf(OFS_SEED_AND_RESULT)
            |=> busRdata == $past(busWdata, 2))
        else $error("seed not read back");
    a_mirror_pair: assert property
        (rdOf(OFS_SEED_AND_RESULT) ##1 rdOf(OFS_RESULT_MIRRORED)
            |=> busRdata == mir($past(busRdata)))
        else $error("mirrored result not bit reversed");
    a_word_stall: assert property
        (dataWr && !busByte |=> !(rdTaken || seedWr) [*2])
        else $error("access taken during word update");
    a_byte_stall: assert property
        (dataWr && busByte |=> !(rdTaken || seedWr))
        else $error("access taken during byte update");
endmodule : crcs_core_asserts

bind crcs_core crcs_core_asserts #(.DEPTH(DEPTH)) chk (.mclk(mclk),
    .rst(rst), .busSel(busSel), .busWrite(busWrite), .busByte(busByte),
    .busAddr(busAddr), .busWdata(busWdata), .busReady(busReady),
    .busRdata(busRdata), .busRvalid(busRvalid));

/* File: test/crcs_master.sv */
// bus master model standing for a core or a transfer engine
// assumes crcs_core bus: request held until busReady, answer next cycle
module crcs_master (
    input wire logic mclk,
    input wire logic busReady,
    input wire logic busRvalid,
    input wire logic [crcs_pkg::DATA_W-1:0] busRdata,
    output logic busSel,
    output logic busWrite,
    output logic busByte,
    output logic [crcs_pkg::ADDR_W-1:0] busAddr,
    output logic [crcs_pkg::DATA_W-1:0] busWdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import crcs_pkg::*;
    int timeouts = 0;
    logic stalled = 1'b0;
    initial
    begin
        busSel = 1'b0;
        busWrite = 1'b0;
        busByte = 1'b0;
        busAddr = 3'h0;
        busWdata = 16'h0000;
    end
    // requests go out in call order, same path for any source
    task automatic req(logic w, logic [2:0] a, logic [15:0] d, logic b);
        int n;
        @(negedge mclk);
        busSel = 1'b1;
        busWrite = w;
        busByte = b;
        busAddr = a;
        busWdata = d;
        #1;
        n = 0;
        while (busReady !== 1'b1 && n < 200)
        begin
            // only a refused data write shows the queue pushing back
            if (w && !a[2])
                stalled = 1'b1;
            @(negedge mclk);
            #1;
            n++;
        end
        if (n == 200)
            timeouts++;
        @(posedge mclk);
    endtask : req
    task automatic write(logic [2:0] a, logic [15:0] d, logic b);
        req(1'b1, a, d, b);
    endtask : write
    // answer stands for the cycle after the taking edge; taking it there
    // lets the next request go out at the very next falling edge
    task automatic read(logic [2:0] a, logic b, output logic [15:0] d);
        req(1'b0, a, 16'h0000, b);
        #1;
        if (busRvalid !== 1'b1)
            timeouts++;
        d = busRdata;
    endtask : read
    // released data lines must not keep showing old data
    task automatic idle();
        @(negedge mclk);
        busSel = 1'b0;
        busWdata = ~busWdata;
    endtask : idle
endmodule : crcs_master

/* File: test/testbench.sv */
// self-checking bench for the signature generator
// assumes crcs_core driven by the master model at the falling edge
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import crcs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic busSel, busWrite, busByte, busReady, busRvalid;
    logic [ADDR_W-1:0] busAddr;
    logic [DATA_W-1:0] busWdata, busRdata, got;
    logic [15:0] crc = 16'hFFFF;
    logic [15:0] din = 16'h0000;
    int miscompares = 0;
    int checked = 0;
    always #10 mclk = ~mclk;
    crcs_master m (.mclk(mclk), .busReady(busReady), .busRvalid(busRvalid),
        .busRdata(busRdata), .busSel(busSel), .busWrite(busWrite),
        .busByte(busByte), .busAddr(busAddr), .busWdata(busWdata));
    crcs_core #(.DEPTH(16)) dut (.mclk(mclk), .rst(rst), .busSel(busSel),
        .busWrite(busWrite), .busByte(busByte), .busAddr(busAddr),
        .busWdata(busWdata), .busReady(busReady), .busRdata(busRdata),
        .busRvalid(busRvalid));
    function automatic logic [15:0] mir(logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
            r[i] = v[15-i];
        return r;
    endfunction : mir
    // serial msb-first lfsr; normal bytes enter mirrored
    function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] b,
                                         logic rev);
        c = c ^ (rev ? {b, 8'h00} : mir({8'h00, b}));
        for (int i = 0; i < 8; i++)
            c = c[15] ? (c << 1) ^ CCITT_POLY : c << 1;
        return c;
    endfunction : fold
    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic wr(logic [2:0] a, logic [15:0] d, logic b);
        m.write(a, d, b);
        if (!a[2] && b)
        begin
            crc = fold(crc, d[7:0], a[1]);
            if (a[0])
                din[15:8] = d[7:0];
            else
                din[7:0] = d[7:0];
        end
        else if (!a[2])
        begin
            crc = fold(fold(crc, d[7:0], a[1]), d[15:8], a[1]);
            din = d;
        end
        else if (!a[1] && !b)
            crc = d;
        else if (!a[1] && a[0])
            crc[15:8] = d[7:0];
        else if (!a[1])
            crc[7:0] = d[7:0];
    endtask : wr
    task automatic rdc(string n, logic [2:0] a, logic b, logic [15:0] e);
        m.read(a, b, got);
        chk(n, e, got);
    endtask : rdc
    task automatic chkall();
        rdc("seed_and_result", 3'h4, 1'b0, crc);
        rdc("result_mirrored", 3'h6, 1'b0, mir(crc));
        rdc("data_in", 3'h0, 1'b0, din);
        rdc("data_in_reversed", 3'h2, 1'b0, din);
        rdc("result high byte", 3'h5, 1'b1, {8'h00, crc[15:8]});
        rdc("mirrored low byte", 3'h6, 1'b1, mir({crc[15:8], 8'h00}));
    endtask : chkall
    initial
    begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        chkall();
        wr(3'h4, 16'hFFFF, 1'b0);
        for (int i = 0; i < 9; i++)
            wr(3'h0, 16'h0031 + 16'(i), 1'b1);
        rdc("ref normal", 3'h4, 1'b0, 16'h89F6);
        rdc("ref normal mirrored", 3'h6, 1'b0, 16'h6F91);
        wr(3'h0, 16'h6F91, 1'b0);
        rdc("checksum appended", 3'h4, 1'b0, 16'h0000);
        rdc("checksum mirrored", 3'h6, 1'b0, 16'h0000);
        wr(3'h4, 16'hFFFF, 1'b0);
        for (int i = 0; i < 4; i++)
            wr(3'h2, 16'h3231 + 16'(i * 16'h0202), 1'b0);
        wr(3'h2, 16'h0039, 1'b1);
        rdc("ref reversed", 3'h4, 1'b0, 16'h29B1);
        rdc("ref reversed mirrored", 3'h6, 1'b0, 16'h8D94);
        chkall();
        wr(3'h4, 16'h1234, 1'b0);
        rdc("seed readback", 3'h4, 1'b0, 16'h1234);
        wr(3'h5, 16'h00AB, 1'b1);
        wr(3'h4, 16'h00CD, 1'b1);
        wr(3'h6, 16'h5555, 1'b0);
        wr(3'h7, 16'h0055, 1'b1);
        rdc("seed byte aliases", 3'h4, 1'b0, 16'hABCD);
        wr(3'h1, 16'h00A5, 1'b1);
        wr(3'h3, 16'h005A, 1'b1);
        chkall();
        // words back to back outrun the engine until the queue refuses
        for (int i = 0; i < 48; i++)
            wr({1'b0, i[0], 1'b0}, 16'hC3A5 ^ 16'(i * 16'h0111), 1'b0);
        chk("queue refused", 16'h0001, {15'h0000, m.stalled});
        chkall();
        m.idle();
        chk("bus timeouts", 16'h0000, 16'(m.timeouts));
        final_report();
    end
endmodule : testbench
